// *** core/ssp_pkg.sv ***
// Constants and types for the serial port block.
// Assumes one processor on the parallel port and tied serial clocks.
package ssp_pkg;
   // Register map; the low address bit picks control or data
   localparam logic [7:0] SSP_DATA_OFS = 8'hec; // tx_holding, rx_buffer
   localparam logic [7:0] SSP_CTRL_OFS = 8'hed; // mode_command_word, status
   // Mode word fields
   localparam int MD_LEN  = 2;                 // [3:2] length minus five
   localparam int MD_PEN  = 4;                 // Parity enable
   localparam int MD_EVEN = 5;                 // Even parity
   localparam int MD_ESD  = 6;                 // Sync: external detect
   localparam int MD_SCS  = 7;                 // Sync: single sync char
   localparam logic [1:0] BAUD_SYNC = 2'h0;
   localparam logic [1:0] BAUD_X16  = 2'h2;
   localparam logic [1:0] BAUD_X64  = 2'h3;
   localparam logic [1:0] STOP_ONE  = 2'h1;    // [7:6] in async mode
   localparam logic [3:0] LEN_BASE  = 4'h5;
   // Serial clocks per bit, minus one
   localparam logic [5:0] DIV_X1  = 6'h00;
   localparam logic [5:0] DIV_X16 = 6'h0f;
   localparam logic [5:0] DIV_X64 = 6'h3f;
   // Command word bits
   localparam int CMD_TX_ENABLE_BIT = 0;
   localparam int CMD_DTR  = 1;
   localparam int CMD_RXE  = 2;
   localparam int CMD_SBRK = 3;
   localparam int CMD_ER   = 4;
   localparam int CMD_RTS  = 5;
   localparam int CMD_IR   = 6;
   localparam int CMD_EH   = 7;
   // Values after reset
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] CMD_RESET  = 8'h00;
   localparam logic [7:0] SYNC_RESET = 8'h00;
   localparam logic [7:0] DOUT_RESET = 8'h00;

   typedef enum logic [1:0] {CTL_MODE, CTL_SYNC1, CTL_SYNC2,
                             CTL_CMD} ssp_ctl_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ssp_rx_t;
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] cmd;
      logic       sync_search_tgl;
   } ssp_cfg_t;
   typedef struct packed {
      logic [7:0] data;
      logic       perr;
      logic       ferr;
   } ssp_rxw_t;
endpackage

// *** core/ssp_top.sv ***
// Serial port: processor port, mode/command sequencer, status, and the
// transmitter and receiver on the serial clock.
// Assumes transmit and receive serial clocks are tied to serial_clock.
`timescale 1ns/10ps
`default_nettype none

module ssp_top
   import ssp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] data_i,
   output logic      [7:0] data_o,
   output logic            data_oe,
   input  wire logic       io_write_n,
   input  wire logic       io_read_n,
   output logic            tx_ready,
   output logic            rx_char_ready,
   output logic            tx_empty_pin,
   input  wire logic       sync_detect_i,
   output logic            sync_detect_o,
   output logic            sync_detect_oe,
   input  wire logic       cts_n,
   input  wire logic       dsr_n,
   output logic            dtr_n,
   output logic            rts_n,
   input  wire logic       serial_clock,
   output logic            txd,
   input  wire logic       rxd
);
   // Shared decode helpers
   function automatic logic [3:0] char_len(input logic [7:0] md);
      char_len = LEN_BASE + {2'b00, md[MD_LEN+1:MD_LEN]};
   endfunction
   function automatic logic [7:0] len_mask(input logic [3:0] n);
      len_mask = 8'hff >> (4'h8 - n);
   endfunction
   function automatic logic par_bit(input logic [7:0] d,
                                    input logic [7:0] md);
      par_bit = ^(d & len_mask(char_len(md))) ^ ~md[MD_EVEN];
   endfunction
   function automatic logic [5:0] bit_div(input logic [7:0] md);
      case (md[1:0])
         BAUD_X16: bit_div = DIV_X16;
         BAUD_X64: bit_div = DIV_X64;
         default:  bit_div = DIV_X1;
      endcase
   endfunction

   // ---------------- Processor side (clk) ----------------
   logic [20:0] pin_s1, pin_s2;
   logic        wr_p, rd_p;
   ssp_ctl_t    ctl;
   logic [7:0]  mode, sync1, sync2, cmd, tx_hold, rx_buf;
   logic        sync_search_tgl, tx_req, rdy, ovr, perr, ferr, sd_flag, cfg_tgl;
   logic [1:0]  ack_sy, txe_sy;
   logic [2:0]  rxev_sy, sdev_sy;
   ssp_cfg_t    cfg_clk;
   ssp_rxw_t    r_word;
   logic        tx_taken, tx_emp, r_tgl, sd_tgl;

   // Pins, two flops before use
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_s1 <= {5'h1f, 16'h0000};
         pin_s2 <= {5'h1f, 16'h0000};
      end else begin
         pin_s1 <= {io_write_n, io_read_n, cts_n, dsr_n, sync_detect_i,
                    addr, data_i};
         pin_s2 <= pin_s1;
      end
   end

   // Decode of the synchronised strobes and address
   wire        s_wr_n  = pin_s2[20];
   wire        s_rd_n  = pin_s2[19];
   wire        s_cts_n = pin_s2[18];
   wire        s_dsr_n = pin_s2[17];
   wire        s_sd    = pin_s2[16];
   wire [7:0]  s_addr  = pin_s2[15:8];
   wire [7:0]  s_data  = pin_s2[7:0];
   wire        sel     = s_addr[7:2] == SSP_DATA_OFS[7:2];
   wire        a_ctl   = s_addr[0] == SSP_CTRL_OFS[0];
   wire        wr_ev   = wr_p & ~s_wr_n & sel;
   wire        rd_ev   = rd_p & ~s_rd_n & sel;
   wire        wr_ctl  = wr_ev & a_ctl;
   wire        wr_dat  = wr_ev & ~a_ctl;
   wire        rd_st   = rd_ev & a_ctl;
   wire        rd_dat  = rd_ev & ~a_ctl;
   wire        cmd_wr  = wr_ctl & (ctl == CTL_CMD);
   wire        er_cmd  = cmd_wr & (s_data[CMD_ER] | s_data[CMD_IR]);
   wire        ir_cmd  = cmd_wr & s_data[CMD_IR];
   wire        m_sync  = mode[1:0] == BAUD_SYNC;
   wire        m_ext   = m_sync & mode[MD_ESD];
   wire        tx_enable_bit    = cmd[CMD_TX_ENABLE_BIT];
   wire        hold_full = tx_req ^ ack_sy[1];
   wire        rx_ev   = rxev_sy[1] ^ rxev_sy[2];
   wire        sd_ev   = sdev_sy[1] ^ sdev_sy[2];
   wire        sd_stat = m_ext ? s_sd : sd_flag;
   wire [7:0]  status  = {~s_dsr_n, sd_stat, ferr, ovr, perr,
                          tx_empty_pin, rx_char_ready, tx_ready};

   // Handshake and direct outputs
   assign tx_ready       = tx_enable_bit & ~s_cts_n & ~hold_full;
   assign rx_char_ready  = rdy & cmd[CMD_RXE];
   assign tx_empty_pin   = tx_enable_bit & txe_sy[1] & ~hold_full;
   assign sync_detect_oe = ~m_ext;
   assign dtr_n          = ~cmd[CMD_DTR];
   assign rts_n          = ~cmd[CMD_RTS];
   assign cfg_clk        = {mode, sync1, sync2, cmd, sync_search_tgl};

   // Mode, sync character and command sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl      <= CTL_MODE;
         mode     <= MODE_RESET;
         sync1    <= SYNC_RESET;
         sync2    <= SYNC_RESET;
         cmd      <= CMD_RESET;
         sync_search_tgl <= 1'b0;
         cfg_tgl  <= 1'b0;
      end else if (wr_ctl) begin
         cfg_tgl <= ~cfg_tgl;            // Tells the link a new word stands
         case (ctl)
            CTL_MODE: begin
               mode <= s_data;
               ctl  <= (s_data[1:0] == BAUD_SYNC) ? CTL_SYNC1 : CTL_CMD;
            end
            CTL_SYNC1: begin
               sync1 <= s_data;
               ctl   <= mode[MD_SCS] ? CTL_CMD : CTL_SYNC2;
            end
            CTL_SYNC2: begin
               sync2 <= s_data;
               ctl   <= CTL_CMD;
            end
            CTL_CMD: begin
               if (s_data[CMD_IR]) begin
                  ctl <= CTL_MODE;
                  cmd <= CMD_RESET;
               end else begin
                  cmd <= s_data;
                  if (s_data[CMD_EH])
                     sync_search_tgl <= ~sync_search_tgl;
               end
            end
            default: ctl <= CTL_MODE;
         endcase
      end
   end

   // Strobe edges, transmit holding register, read data
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_p    <= 1'b1;
         rd_p    <= 1'b1;
         tx_hold <= 8'h00;
         tx_req  <= 1'b0;
         data_o  <= DOUT_RESET;
         data_oe <= 1'b0;
      end else begin
         wr_p    <= s_wr_n;
         rd_p    <= s_rd_n;
         data_oe <= ~s_rd_n & sel;
         if (wr_dat) begin
            tx_hold <= s_data;
            tx_req  <= ~tx_req;
         end
         if (rd_ev)
            data_o <= a_ctl ? status : rx_buf;
      end
   end

   // Crossings from the serial clock and the receive flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_sy  <= 2'b00;
         txe_sy  <= 2'b11;
         rxev_sy <= 3'b000;
         sdev_sy <= 3'b000;
         rx_buf  <= 8'h00;
         rdy     <= 1'b0;
         ovr     <= 1'b0;
         perr    <= 1'b0;
         ferr    <= 1'b0;
         sd_flag <= 1'b0;
      end else begin
         ack_sy  <= {ack_sy[0], tx_taken};
         txe_sy  <= {txe_sy[0], tx_emp};
         rxev_sy <= {rxev_sy[1:0], r_tgl};
         sdev_sy <= {sdev_sy[1:0], sd_tgl};
         if (rx_ev)
            rx_buf <= r_word.data;
         rdy  <= rx_ev | (rdy & ~rd_dat & ~ir_cmd);
         ovr  <= (rx_ev & rdy & ~rd_dat) | (ovr & ~er_cmd);
         perr <= (rx_ev & r_word.perr) | (perr & ~er_cmd);
         ferr <= (rx_ev & r_word.ferr) | (ferr & ~er_cmd);
         sd_flag <= sd_ev | (sd_flag & ~rd_st);
      end
   end
   assign sync_detect_o = sd_flag;

   // ---------------- Serial side (serial_clock) ----------------
   logic [1:0]  lrst_sy;
   logic [2:0]  cfgt_sy;
   ssp_cfg_t    cfg;
   logic [3:0]  lnk_s1, lnk_s2;
   wire         lrst_n = lrst_sy[1];

   // Reset release and configuration crossing
   always_ff @(posedge serial_clock or negedge rstn) begin
      if (!rstn)
         lrst_sy <= 2'b00;
      else
         lrst_sy <= {lrst_sy[0], 1'b1};
   end
   always_ff @(posedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         cfgt_sy <= 3'b000;
         cfg    <= '0;
         lnk_s1 <= 4'hd;
         lnk_s2 <= 4'hd;
      end else begin
         // Only the toggle is synchronised; the word is taken whole once
         // it has stood still, so no mixed old and new bits are seen
         cfgt_sy <= {cfgt_sy[1:0], cfg_tgl};
         if (cfgt_sy[1] ^ cfgt_sy[2])
            cfg <= cfg_clk;
         lnk_s1 <= {cts_n, rxd, sync_detect_i, tx_req};
         lnk_s2 <= lnk_s1;
      end
   end

   // Link decode of the configuration
   wire         l_cts_n = lnk_s2[3];
   wire         l_rxd   = lnk_s2[2];
   wire         l_sd    = lnk_s2[1];
   wire         l_req   = lnk_s2[0];
   wire [3:0]   lc_len  = char_len(cfg.mode);
   wire         lc_pen  = cfg.mode[MD_PEN];
   wire         lc_sync = cfg.mode[1:0] == BAUD_SYNC;
   wire         lc_ext  = lc_sync & cfg.mode[MD_ESD];
   wire [5:0]   lc_div  = bit_div(cfg.mode);
   wire         lc_two  = lc_sync ? ~cfg.mode[MD_SCS]
                                  : cfg.mode[7:6] != STOP_ONE;
   wire         l_tx_enable_bit  = cfg.cmd[CMD_TX_ENABLE_BIT];

   // Transmitter frame building
   logic        tx_busy, tx_on, tx_fill2;
   logic [11:0] tx_sh;
   logic [3:0]  tx_left;
   logic [5:0]  tx_div;
   wire tx_avail = (l_req != tx_taken) & l_tx_enable_bit & ~l_cts_n;
   wire tx_fill  = lc_sync & tx_on & l_tx_enable_bit & ~tx_avail;
   wire [7:0]  tx_src  = tx_avail ? tx_hold
                                  : (tx_fill2 ? cfg.sync2 : cfg.sync1);
   wire [15:0] tx_body = (16'hffff << lc_len)
                         | {8'h00, tx_src & len_mask(lc_len)};
   wire [15:0] tx_pbit = {15'h0000, par_bit(tx_src, cfg.mode)} << lc_len;
   wire [15:0] tx_par  = lc_pen ? ((tx_body & ~(16'h0001 << lc_len))
                                   | tx_pbit) : tx_body;
   wire [15:0] tx_frm  = lc_sync ? tx_par
                                 : {tx_par[14:0], 1'b0};
   wire [3:0]  tx_nb   = lc_len + {3'b000, lc_pen}
                         + (lc_sync ? 4'h0 : (lc_two ? 4'h3 : 4'h2));
   wire tx_end  = tx_busy & (tx_div == 6'h00);
   wire tx_free = ~tx_busy | (tx_end & (tx_left == 4'h1));
   wire tx_load = tx_free & (tx_avail | tx_fill);

   // Transmitter shifts on the falling serial clock edge
   always_ff @(negedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         tx_busy  <= 1'b0;
         tx_on    <= 1'b0;
         tx_fill2 <= 1'b0;
         tx_sh    <= 12'hfff;
         tx_left  <= 4'h0;
         tx_div   <= 6'h00;
         tx_taken <= 1'b0;
         tx_emp   <= 1'b1;
         txd      <= 1'b1;
      end else begin
         txd <= ~cfg.cmd[CMD_SBRK] & tx_sh[0];
         if (tx_load) begin
            tx_busy <= 1'b1;
            tx_sh   <= tx_frm[11:0];
            tx_left <= tx_nb;
            tx_div  <= lc_div;
         end else if (tx_end) begin
            tx_busy <= tx_left != 4'h1;
            tx_sh   <= {1'b1, tx_sh[11:1]};
            tx_left <= tx_left - 4'h1;
            tx_div  <= lc_div;
         end else if (tx_busy) begin
            tx_div  <= tx_div - 6'h01;
         end
         if (tx_load & tx_avail) begin
            tx_taken <= l_req;
            tx_on    <= lc_sync;
            tx_fill2 <= 1'b0;
         end else if (tx_load) begin
            tx_fill2 <= lc_two & ~tx_fill2;
         end else if (!l_tx_enable_bit) begin
            tx_on    <= 1'b0;
         end
         if (lc_sync)
            tx_emp <= tx_load ? tx_fill : tx_emp;
         else
            tx_emp <= ~tx_busy & ~tx_avail;
      end
   end

   // Receiver assembly helpers
   ssp_rx_t     r_state;
   logic [5:0]  r_div;
   logic [3:0]  r_idx;
   logic [7:0]  r_sh, r_hsh;
   logic        r_pb, sync_search, wait2, rxd_p, sync_search_p;
   wire [7:0] r_full  = {l_rxd, r_hsh[7:1]};
   wire [7:0] r_align = r_full >> (4'h8 - lc_len);
   wire [7:0] r_mask  = len_mask(lc_len);
   wire [3:0] r_tot   = lc_len + {3'b000, lc_pen};
   wire [7:0] r_dnext = ((r_idx < lc_len) & l_rxd)
                        ? (r_sh | (8'h01 << r_idx[2:0])) : r_sh;
   wire       r_pnext = (r_idx == lc_len) ? l_rxd : r_pb;
   wire       r_cend  = lc_sync ? (r_idx == r_tot - 4'h1)
                                : (r_idx == r_tot);
   wire       r_perr  = lc_pen
                        & (r_pnext != par_bit(r_dnext, cfg.mode));
   wire       sync_search_ev = sync_search_p ^ cfg.sync_search_tgl;
   wire       sync_search_hit = sync_search & (lc_ext ? l_sd
                         : r_align == (cfg.sync1 & r_mask));
   wire       sync2_ok = (r_dnext & r_mask) == (cfg.sync2 & r_mask);

   // Receiver samples on the rising serial clock edge
   always_ff @(posedge serial_clock or negedge lrst_n) begin
      if (!lrst_n) begin
         r_state <= RX_IDLE;
         r_div   <= 6'h00;
         r_idx   <= 4'h0;
         r_sh    <= 8'h00;
         r_hsh   <= 8'h00;
         r_pb    <= 1'b0;
         sync_search    <= 1'b1;
         wait2   <= 1'b0;
         rxd_p   <= 1'b1;
         sync_search_p  <= 1'b0;
         r_tgl   <= 1'b0;
         sd_tgl  <= 1'b0;
         r_word  <= '0;
      end else begin
         rxd_p  <= l_rxd;
         sync_search_p <= cfg.sync_search_tgl;
         r_hsh  <= r_full;
         if (sync_search_ev) begin
            sync_search    <= 1'b1;
            wait2   <= 1'b0;
            r_state <= RX_IDLE;
         end else begin
            case (r_state)
               RX_IDLE: begin
                  if (lc_sync & sync_search_hit) begin
                     sync_search    <= 1'b0;
                     wait2   <= ~lc_ext & lc_two;
                     if (~lc_ext & ~lc_two)
                        sd_tgl <= ~sd_tgl;
                     r_state <= RX_BITS;
                     r_div   <= 6'h00;
                     r_idx   <= 4'h0;
                     r_sh    <= 8'h00;
                  end else if (~lc_sync & rxd_p & ~l_rxd) begin
                     r_state <= RX_START;
                     r_div   <= lc_div >> 1;
                  end
               end
               RX_START: begin
                  if (r_div != 6'h00) begin
                     r_div <= r_div - 6'h01;
                  end else if (~l_rxd) begin
                     r_state <= RX_BITS;
                     r_div   <= lc_div;
                     r_idx   <= 4'h0;
                     r_sh    <= 8'h00;
                  end else begin
                     r_state <= RX_IDLE;
                  end
               end
               RX_BITS: begin
                  if (r_div != 6'h00) begin
                     r_div <= r_div - 6'h01;
                  end else begin
                     r_div <= lc_div;
                     r_sh  <= r_dnext;
                     r_pb  <= r_pnext;
                     r_idx <= r_idx + 4'h1;
                     if (r_cend) begin
                        r_idx <= 4'h0;
                        r_sh  <= 8'h00;
                        if (!lc_sync)
                           r_state <= RX_IDLE;
                        if (wait2) begin
                           wait2 <= 1'b0;
                           if (sync2_ok) begin
                              sd_tgl <= ~sd_tgl;
                           end else begin
                              sync_search    <= 1'b1;
                              r_state <= RX_IDLE;
                           end
                        end else begin
                           r_word.data <= r_dnext & r_mask;
                           r_word.perr <= r_perr;
                           r_word.ferr <= ~lc_sync & ~l_rxd;
                           r_tgl       <= ~r_tgl;
                        end
                     end
                  end
               end
               default: r_state <= RX_IDLE;
            endcase
         end
      end
   end
endmodule

`default_nettype wire

// *** tb/ssp_link_model.sv ***
// Far-side terminal: sends framed characters on rxd, captures txd.
// Assumes 16 serial clocks per bit (one in sync mode), LSB first.
`timescale 1ns/10ps
`default_nettype none
module ssp_link_model (
   input  wire logic sclk,
   input  wire logic txd,
   output logic      rxd
);
   logic [7:0] got;  // Last captured character
   int         ncap; // Characters captured
   logic [7:0] sh;
   // Drives one frame LSB first, each bit for 16 falling edges
   task automatic send(input logic [11:0] f);
      for (int i = 0; i < 12; i++) begin
         @(negedge sclk) rxd = f[i];
         repeat (15) @(negedge sclk);
      end
   endtask
   // Drives n copies of a character, one bit per falling edge
   task automatic send1x(input logic [7:0] c, input int n);
      for (int k = 0; k < n; k++)
         for (int i = 0; i < 8; i++)
            @(negedge sclk) rxd = c[i];
   endtask
   // Finds a start bit, rechecks mid-bit, then samples bit centres
   initial begin
      rxd = 1'b1;
      ncap = 0;
      forever begin
         @(posedge sclk iff txd === 1'b0);
         repeat (8) @(posedge sclk);
         if (txd === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
               repeat (16) @(posedge sclk);
               sh[i] = txd;
            end
            got = sh;
            ncap++;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/ssp_top_asserts.sv ***
// Checker for the serial port: bus timing, ready flags and reset levels.
// Assumes it is bound to ssp_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ssp_chk (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic [7:0] addr,
   input wire logic [7:0] data_o,
   input wire logic       data_oe,
   input wire logic       io_write_n,
   input wire logic       io_read_n,
   input wire logic       tx_ready,
   input wire logic       rx_char_ready,
   input wire logic       txd,
   input wire logic       dtr_n,
   input wire logic       sync_detect_o,
   input wire logic       sync_detect_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Port decode and the two strobe starts
   wire logic sel = addr[7:2] == 6'h3b;
   sequence data_wr;
      $fell(io_write_n) && sel && !addr[0];
   endsequence
   sequence data_rd;
      $fell(io_read_n) && sel && !addr[0];
   endsequence
   a_oe_on_read: assert property ($rose(data_oe) |-> sel && !io_read_n)
      else $error("data_oe rose without a selected read");
   a_oe_quiet: assert property (io_read_n [*5] |-> !data_oe)
      else $error("data_oe high without a read");
   a_dout_on_read: assert property ($changed(data_o) |-> sel && !io_read_n)
      else $error("data_o changed outside a read");
   a_tx_ready_drop: assert property (data_wr |-> ##[1:5] !tx_ready)
      else $error("tx_ready stayed high after a data write");
   a_rx_char_ready_drop: assert property (data_rd |-> ##[1:5] !rx_char_ready)
      else $error("rx_char_ready stayed high after a data read");
   a_rx_char_ready_hold: assert property (rx_char_ready && io_read_n && io_write_n
      && $past(io_read_n, 3) && $past(io_write_n, 3) |=> rx_char_ready)
      else $error("rx_char_ready dropped without a read");
   a_reset_idle: assert property ($rose(rstn) |-> txd && dtr_n
      && !sync_detect_o && sync_detect_oe)
      else $error("outputs not idle after reset");
   a_dtr_on_ctrl: assert property ($changed(dtr_n) |-> sel && addr[0]
      && !io_write_n)
      else $error("dtr_n changed without a control write");
endmodule
bind ssp_top ssp_chk u_chk (.clk, .rstn, .addr, .data_o, .data_oe,
   .io_write_n, .io_read_n, .tx_ready, .rx_char_ready, .txd, .dtr_n,
   .sync_detect_o, .sync_detect_oe);
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench: strobed port accesses, link traffic and errors.
// Assumes ssp_top, the link model and a free-running 6 ns link clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ssp_pkg::*;
   logic       clk = 1'b0, sclk = 1'b0, rstn = 1'b0;
   logic [7:0] addr = 8'h00, data_i = 8'h00, data_o, q;
   logic       io_write_n = 1'b1, io_read_n = 1'b1, cts_n = 1'b0;
   logic       dsr_n = 1'b0, data_oe, tx_ready, rx_char_ready, txd, rxd;
   logic       tx_empty_pin, sync_detect_o, sync_detect_oe, dtr_n, rts_n;
   int         err_count = 0, cmp_count = 0, cyc = 0;
   // Pin level, far side drives it in external sync; outputs packed
   logic       sd_drv = 1'b0;
   wire logic  sd_pin = sync_detect_oe ? sync_detect_o : sd_drv;
   wire logic [7:0] pins = {txd, tx_ready, rx_char_ready, dtr_n,
      sync_detect_o, sync_detect_oe, tx_empty_pin, 1'b0};
   always #2.5 clk = ~clk;
   always #3 sclk = ~sclk;
   ssp_top uut (.clk, .rstn, .addr, .data_i, .data_o, .data_oe,
      .io_write_n, .io_read_n, .tx_ready, .rx_char_ready, .tx_empty_pin,
      .sync_detect_i(sd_pin), .sync_detect_o, .sync_detect_oe, .cts_n,
      .dsr_n, .dtr_n, .rts_n, .serial_clock(sclk), .txd, .rxd);
   ssp_link_model link (.sclk, .txd, .rxd);
   task automatic chk(input logic [7:0] seen, exp, input string nm);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One access: set-up, five-cycle strobe, read data taken, idle gap
   task automatic acc(input logic wr, input logic [7:0] a, d);
      addr = a;
      data_i = d;
      repeat (3) @(posedge clk);
      #1 if (wr) io_write_n = 1'b0; else io_read_n = 1'b0;
      repeat (5) @(posedge clk);
      q = data_o;
      #1 io_write_n = 1'b1;
      io_read_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic wait_rx();
      @(posedge clk);
      for (int i = 0; i < 2000 && rx_char_ready !== 1'b1; i++)
         @(posedge clk);
      #1;
   endtask
   task automatic wait_cap(input int n);
      @(posedge clk);
      for (int i = 0; i < 4000 && link.ncap < n; i++)
         @(posedge clk);
      #1;
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      #1 rstn = 1'b1;
      chk(pins, 8'h94, "reset pins");
      acc(1, 8'hed, 8'h4e);
      acc(1, 8'hed, 8'h17);
      chk(pins, 8'hc6, "enabled pins");
      acc(0, 8'hef, 8'h00);
      chk(q & 8'h87, 8'h85, "idle status");
      acc(1, 8'hee, 8'h55);
      chk(pins & 8'h02, 8'h00, "empty after load");
      wait_cap(1);
      chk(link.got, 8'h55, "sent char");
      link.send({3'h7, 8'ha3, 1'b0});
      wait_rx();
      acc(0, 8'hec, 8'h00);
      chk(q, 8'ha3, "rx char");
      chk(pins & 8'h20, 8'h00, "rx ready after read");
      link.send({3'h7, 8'h11, 1'b0});
      link.send({3'h7, 8'h22, 1'b0});
      wait_rx();
      acc(0, 8'hed, 8'h00);
      chk(q & 8'h3a, 8'h12, "overrun status");
      acc(0, 8'hec, 8'h00);
      chk(q, 8'h22, "overrun char");
      link.send({3'h6, 8'h5a, 1'b0});
      wait_rx();
      acc(0, 8'hec, 8'h00);
      chk(q, 8'h5a, "char after bad stop");
      acc(0, 8'hed, 8'h00);
      chk(q & 8'h30, 8'h30, "framing status");
      acc(1, 8'hed, 8'h17);
      acc(0, 8'hed, 8'h00);
      chk(q & 8'h38, 8'h00, "errors cleared");
      acc(1, 8'hf1, 8'h40);
      chk(pins, 8'hc6, "foreign write");
      acc(1, 8'hed, 8'h40);
      chk(pins, 8'h94, "internal reset");
      acc(1, 8'hed, 8'h7e);
      acc(1, 8'hed, 8'h17);
      link.send({3'h7, 8'h03, 1'b0});
      wait_rx();
      acc(0, 8'hed, 8'h00);
      chk(q & 8'h0a, 8'h0a, "parity status");
      cts_n = 1'b1;
      acc(1, 8'hec, 8'h81);
      repeat (300) @(posedge clk);
      chk(pins & 8'h80, 8'h80, "held by cts");
      #1 cts_n = 1'b0;
      wait_cap(2);
      chk(link.got, 8'h81, "sent after cts");
      acc(1, 8'hed, 8'h40);
      acc(1, 8'hed, 8'h42);
      acc(1, 8'hed, 8'h17);
      link.send(12'hffe);
      wait_rx();
      acc(0, 8'hec, 8'h00);
      chk(q, 8'h1f, "short char");
      acc(1, 8'hed, 8'h3f);
      repeat (10) @(posedge clk);
      chk(pins & 8'h80, 8'h00, "break level");
      chk({7'h00, rts_n}, 8'h00, "rts level");
      acc(1, 8'hed, 8'h40);
      acc(1, 8'hed, 8'h8c);
      acc(1, 8'hed, 8'h16);
      acc(1, 8'hed, 8'h84);
      link.send1x(8'h16, 1);
      fork
         link.send1x(8'ha5, 40);
         begin
            repeat (20) @(posedge clk);
            #1 chk(pins & 8'h08, 8'h08, "sync detect pin");
            acc(0, 8'hed, 8'h00);
            chk(q & 8'h40, 8'h40, "sync detect status");
            chk(pins & 8'h08, 8'h00, "sync detect cleared");
            acc(1, 8'hed, 8'h84);
            acc(0, 8'hec, 8'h00);
            chk(q, 8'ha5, "sync char stream");
         end
      join
      acc(1, 8'hed, 8'h40);
      acc(1, 8'hed, 8'hcc);
      acc(1, 8'hed, 8'h00);
      acc(1, 8'hed, 8'h01);
      chk(pins & 8'h86, 8'h82, "sync idle line");
      sd_drv = 1'b1;
      acc(0, 8'hed, 8'h00);
      sd_drv = 1'b0;
      chk(q & 8'h40, 8'h40, "external sync status");
      finish_test();
   end
endmodule
`default_nettype wire
